//--- hdl/tag_cmd_pkg.sv
// Constants, field positions and carrier types for the tag command block.
// Assumes a 32-bit APB master and one 100 MHz clock shared with the block.
//
// Behaviour
// - Quiet set, sticky clear: answer, then go quiet; both clear: keep state.
// - Quiet clear, sticky set: answer, then go to sticky quiet.
// - Both quiet bits set: answer only while already in sticky quiet.
// - Extended census with option set carries truncated or full identifier.
// - Extended census with option clear carries no identifier at all.
// - Truncated length: 64-4-mask bits (16 slots) or 64-mask, whole bytes.
// - Extended answer order: flags byte, identifier bytes, block data, CRC16.
// - Census also accepted addressed or selected, inventory flag clear.
// - Addressed or selected census behaves like a block read.
// - Addressed or selected census answers in the first slot only.
// - Code a1 is the quick census read, handled like census read.
// - Quick census answers at double return rate, 53 or 13 kbit.
// - Forward rate and turnaround stay standard for the quick census.
// - Quick census answers with single subcarrier only.
// - Code a2 arms article surveillance unless frozen.
// - Code a3 disarms article surveillance unless frozen.
// - Code a4 freezes surveillance state and identifier for good; the block freezes only the armed state, the identifier stays writable.
// - With protection on, alarm commands run only after password presented.
// - Alarm commands use write timing, any option, flags, error code, CRC.
// - Extended bit 2 clear gives truncated identifier, set gives full one.
// - Top bit of mask length selects extended mode and an options byte.
package tag_cmd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD     = 8'h00;
  localparam logic [7:0] OFF_CTRL    = 8'h04;
  localparam logic [7:0] OFF_STATE   = 8'h08;
  localparam logic [7:0] OFF_UID_LO  = 8'h0c;
  localparam logic [7:0] OFF_UID_HI  = 8'h10;
  localparam logic [7:0] OFF_RESP    = 8'h14;
  localparam logic [7:0] OFF_RID_LO  = 8'h18;
  localparam logic [7:0] OFF_RID_HI  = 8'h1c;

  // Command codes
  localparam logic [7:0] CMD_CENSUS  = 8'ha0;
  localparam logic [7:0] CMD_QUICK   = 8'ha1;
  localparam logic [7:0] CMD_ARM     = 8'ha2;
  localparam logic [7:0] CMD_DISARM  = 8'ha3;
  localparam logic [7:0] CMD_FREEZE  = 8'ha4;

  // Request flag positions
  localparam int FLG_SUBCAR  = 0;
  localparam int FLG_INVENT  = 2;
  localparam int FLG_SELECT  = 4;
  localparam int FLG_ONESLOT = 5;
  localparam int FLG_OPTION  = 6;

  // Extended option positions (bit n of the table is index n-1)
  localparam int EXT_ALARM_ONLY = 0;
  localparam int EXT_FULL_ID    = 1;
  localparam int EXT_QUIET      = 5;
  localparam int EXT_STICKY     = 6;
  localparam int MASK_EXT_BIT   = 7;

  // Identifier sizing
  localparam logic [7:0] ID_BITS      = 8'd64;
  localparam logic [7:0] SLOT_BITS    = 8'd4;
  localparam logic [3:0] ID_BYTES_MAX = 4'd8;

  // Error codes, arbitrary values
  localparam logic [7:0] ERR_LOCKED = 8'h12;
  localparam logic [7:0] ERR_NOAUTH = 8'h0f;

  // Reset values
  localparam logic [63:0] UID_RST  = 64'h0;
  localparam logic [1:0]  CTRL_RST = 2'h0;

  typedef enum logic [1:0] {
    ST_READY,
    ST_SELECTED,
    ST_QUIET,
    ST_STICKY
  } tag_state_t;

  typedef struct packed {
    logic [7:0] ext_opt;
    logic [7:0] mask_len;
    logic [7:0] flags;
    logic [7:0] code;
  } req_t;

  typedef struct packed {
    logic        first_slot;
    logic        block_read;
    logic        fast_rate;
    logic        single_sub;
    logic        write_timing;
    logic        silent;
    logic        err;
    logic [7:0]  err_code;
    logic [3:0]  id_bytes;
    logic [63:0] id_data;
  } resp_t;

endpackage : tag_cmd_pkg

//--- hdl/tag_census_alarm.sv
// Census read and surveillance command interpreter with APB registers.
// Assumes the frame decoder hands each checked request over APB and the
// transmitter reads the answer descriptor back; CRC and bit timing are theirs.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tag_census_alarm (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output tag_cmd_pkg::resp_t        resp_o,
  output logic                      resp_pulse_o,
  output logic                      armed_o,
  output logic                      frozen_o
);

  tag_cmd_pkg::req_t       req;
  tag_cmd_pkg::resp_t      resp_d;
  tag_cmd_pkg::resp_t      resp_q;
  tag_cmd_pkg::tag_state_t state_q;
  tag_cmd_pkg::tag_state_t state_d;
  logic [63:0]             uid_q;
  logic [1:0]              ctrl_q;
  logic                    armed_q;
  logic                    frozen_q;
  logic                    pulse_q;
  logic                    wr_en;
  logic                    rd_mapped;
  logic                    cmd_go;
  logic                    is_census;
  logic                    is_alarm;
  logic                    ext_mode;
  logic                    inv_mode;
  logic                    slots16;
  logic                    quiet_b;
  logic                    sticky_b;
  logic                    answer;
  logic                    auth_ok;
  logic [6:0]              mask_bits;
  logic [7:0]              sub_bits;
  logic [7:0]              left_bits;
  logic [3:0]              trunc_bytes;
  logic [3:0]              id_bytes;
  logic [6:0]              id_shift;

  // Zero wait states keep the transmitter's turnaround budget untouched
  assign pready_o = 1'b1;
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign cmd_go   = wr_en && (paddr_i == tag_cmd_pkg::OFF_CMD);
  assign req      = tag_cmd_pkg::req_t'(pwdata_i);

  always_comb begin
    case (paddr_i)
      tag_cmd_pkg::OFF_CMD,
      tag_cmd_pkg::OFF_CTRL,
      tag_cmd_pkg::OFF_STATE,
      tag_cmd_pkg::OFF_UID_LO,
      tag_cmd_pkg::OFF_UID_HI,
      tag_cmd_pkg::OFF_RESP,
      tag_cmd_pkg::OFF_RID_LO,
      tag_cmd_pkg::OFF_RID_HI: rd_mapped = 1'b1;
      default:                 rd_mapped = 1'b0;
    endcase
  end

  assign pslverr_o = psel_i && penable_i && !rd_mapped;

  always_comb begin
    prdata_o = 32'h0;
    case (paddr_i)
      tag_cmd_pkg::OFF_CTRL:   prdata_o = {30'h0, ctrl_q};
      tag_cmd_pkg::OFF_STATE:  prdata_o = {28'h0, frozen_q, armed_q, state_q};
      tag_cmd_pkg::OFF_UID_LO: prdata_o = uid_q[31:0];
      tag_cmd_pkg::OFF_UID_HI: prdata_o = uid_q[63:32];
      tag_cmd_pkg::OFF_RESP:   prdata_o = {9'h0, resp_q[82:60]};
      tag_cmd_pkg::OFF_RID_LO: prdata_o = resp_q.id_data[31:0];
      tag_cmd_pkg::OFF_RID_HI: prdata_o = resp_q.id_data[63:32];
      default:                 prdata_o = 32'h0;
    endcase
  end

  // Request decode
  assign is_census = (req.code == tag_cmd_pkg::CMD_CENSUS) ||
                     (req.code == tag_cmd_pkg::CMD_QUICK);
  assign is_alarm  = (req.code == tag_cmd_pkg::CMD_ARM) ||
                     (req.code == tag_cmd_pkg::CMD_DISARM) ||
                     (req.code == tag_cmd_pkg::CMD_FREEZE);
  assign ext_mode  = req.mask_len[tag_cmd_pkg::MASK_EXT_BIT];
  assign inv_mode  = req.flags[tag_cmd_pkg::FLG_INVENT];
  assign mask_bits = req.mask_len[6:0];
  // Outside inventory there is no slot count, so one slot is assumed
  assign slots16   = inv_mode && !req.flags[tag_cmd_pkg::FLG_ONESLOT];
  assign quiet_b   = ext_mode && req.ext_opt[tag_cmd_pkg::EXT_QUIET];
  assign sticky_b  = ext_mode && req.ext_opt[tag_cmd_pkg::EXT_STICKY];
  // Protection enable is ctrl bit 0, password presented is ctrl bit 1
  assign auth_ok   = !ctrl_q[0] || ctrl_q[1];

  // Identifier length
  assign sub_bits = slots16 ? (tag_cmd_pkg::ID_BITS - tag_cmd_pkg::SLOT_BITS)
                            : tag_cmd_pkg::ID_BITS;
  assign left_bits = ({1'b0, mask_bits} >= sub_bits) ? 8'h0
                     : (sub_bits - {1'b0, mask_bits});
  assign trunc_bytes = 4'((left_bits + 8'h07) >> 3);

  always_comb begin
    id_bytes = 4'h0;
    if (!req.flags[tag_cmd_pkg::FLG_OPTION]) begin
      id_bytes = 4'h0;
    end else if (ext_mode && req.ext_opt[tag_cmd_pkg::EXT_FULL_ID]) begin
      id_bytes = tag_cmd_pkg::ID_BYTES_MAX;
    end else begin
      id_bytes = trunc_bytes;
    end
  end

  // The high bytes not covered by the mask go out whole, not zero padded
  assign id_shift = 7'({3'h0, tag_cmd_pkg::ID_BYTES_MAX - id_bytes} << 3);

  // Who answers a census read
  always_comb begin
    answer = 1'b1;
    if (inv_mode) begin
      if (quiet_b && sticky_b) begin
        answer = (state_q == tag_cmd_pkg::ST_STICKY);
      end else begin
        answer = (state_q == tag_cmd_pkg::ST_READY) ||
                 (state_q == tag_cmd_pkg::ST_SELECTED);
      end
    end else if (req.flags[tag_cmd_pkg::FLG_SELECT]) begin
      answer = (state_q == tag_cmd_pkg::ST_SELECTED);
    end
    if (quiet_b && sticky_b && !inv_mode) begin
      answer = (state_q == tag_cmd_pkg::ST_STICKY);
    end
    if (ext_mode && req.ext_opt[tag_cmd_pkg::EXT_ALARM_ONLY] && !armed_q) begin
      answer = 1'b0;
    end
  end

  // Answer descriptor; flags, block data and CRC are appended downstream
  always_comb begin
    resp_d          = '0;
    resp_d.silent   = 1'b1;
    if (is_census) begin
      resp_d.silent     = !answer;
      resp_d.id_bytes   = id_bytes;
      resp_d.id_data    = uid_q >> id_shift;
      resp_d.first_slot = !inv_mode;
      resp_d.block_read = !inv_mode;
      if (req.code == tag_cmd_pkg::CMD_QUICK) begin
        resp_d.fast_rate  = 1'b1;
        resp_d.single_sub = 1'b1;
      end else begin
        resp_d.single_sub = !req.flags[tag_cmd_pkg::FLG_SUBCAR];
      end
    end else if (is_alarm) begin
      resp_d.silent       = 1'b0;
      resp_d.write_timing = 1'b1;
      resp_d.single_sub   = !req.flags[tag_cmd_pkg::FLG_SUBCAR];
      if (!auth_ok) begin
        resp_d.err      = 1'b1;
        resp_d.err_code = tag_cmd_pkg::ERR_NOAUTH;
      end else if (frozen_q && (req.code != tag_cmd_pkg::CMD_FREEZE)) begin
        resp_d.err      = 1'b1;
        resp_d.err_code = tag_cmd_pkg::ERR_LOCKED;
      end
    end
  end

  // Tag state: software may place it, census reads may quiet it
  always_comb begin
    state_d = state_q;
    if (wr_en && (paddr_i == tag_cmd_pkg::OFF_STATE)) begin
      state_d = tag_cmd_pkg::tag_state_t'(pwdata_i[1:0]);
    end else if (cmd_go && is_census && answer) begin
      if (quiet_b && !sticky_b) begin
        state_d = tag_cmd_pkg::ST_QUIET;
      end else if (!quiet_b && sticky_b) begin
        state_d = tag_cmd_pkg::ST_STICKY;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= tag_cmd_pkg::ST_READY;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      uid_q  <= tag_cmd_pkg::UID_RST;
      ctrl_q <= tag_cmd_pkg::CTRL_RST;
    end else if (wr_en) begin
      case (paddr_i)
        tag_cmd_pkg::OFF_UID_LO: uid_q[31:0]  <= pwdata_i;
        tag_cmd_pkg::OFF_UID_HI: uid_q[63:32] <= pwdata_i;
        tag_cmd_pkg::OFF_CTRL:   ctrl_q       <= pwdata_i[1:0];
        default: ;
      endcase
    end
  end

  // Surveillance mode; freezing is one way until reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      armed_q  <= 1'b0;
      frozen_q <= 1'b0;
    end else if (cmd_go && auth_ok) begin
      case (req.code)
        tag_cmd_pkg::CMD_ARM:    armed_q  <= frozen_q ? armed_q : 1'b1;
        tag_cmd_pkg::CMD_DISARM: armed_q  <= frozen_q ? armed_q : 1'b0;
        tag_cmd_pkg::CMD_FREEZE: frozen_q <= 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      resp_q  <= '0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= cmd_go;
      if (cmd_go) begin
        resp_q <= resp_d;
      end
    end
  end

  assign resp_o       = resp_q;
  assign resp_pulse_o = pulse_q;
  assign armed_o      = armed_q;
  assign frozen_o     = frozen_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  quiet_entry_a: assert property (
    cmd_go && is_census && answer && quiet_b && !sticky_b
    |=> state_q == tag_cmd_pkg::ST_QUIET)
    else $error("quiet bit did not move tag to quiet");

  state_keep_a: assert property (
    cmd_go && is_census && !quiet_b && !sticky_b &&
    !(wr_en && paddr_i == tag_cmd_pkg::OFF_STATE)
    |=> $stable(state_q))
    else $error("census without quiet bits changed state");

  sticky_entry_a: assert property (
    cmd_go && is_census && answer && !quiet_b && sticky_b
    |=> state_q == tag_cmd_pkg::ST_STICKY)
    else $error("sticky bit did not move tag to sticky quiet");

  both_quiet_a: assert property (
    cmd_go && is_census && quiet_b && sticky_b &&
    state_q != tag_cmd_pkg::ST_STICKY
    |=> resp_pulse_o && resp_o.silent)
    else $error("tag answered with both quiet bits outside sticky");

  id_absent_a: assert property (
    cmd_go && is_census && !req.flags[tag_cmd_pkg::FLG_OPTION]
    |=> resp_o.id_bytes == 4'h0)
    else $error("identifier present with option clear");

  full_id_a: assert property (
    cmd_go && is_census && ext_mode && req.flags[tag_cmd_pkg::FLG_OPTION] &&
    req.ext_opt[tag_cmd_pkg::EXT_FULL_ID]
    |=> resp_o.id_bytes == 4'h8)
    else $error("full identifier not eight bytes");

  one_slot_len_a: assert property (
    cmd_go && is_census && !slots16 && req.flags[tag_cmd_pkg::FLG_OPTION] &&
    !(ext_mode && req.ext_opt[tag_cmd_pkg::EXT_FULL_ID]) && mask_bits < 7'd64
    |=> resp_o.id_bytes == 4'((8'd71 - {1'b0, $past(mask_bits)}) >> 3))
    else $error("one slot truncated length wrong");

  first_slot_a: assert property (
    cmd_go && is_census && !inv_mode
    |=> resp_o.first_slot && resp_o.block_read)
    else $error("addressed census not limited to first slot");

  quick_rate_a: assert property (
    cmd_go && req.code == tag_cmd_pkg::CMD_QUICK
    |=> resp_o.fast_rate && resp_o.single_sub)
    else $error("quick census not double rate single subcarrier");

  arm_take_a: assert property (
    cmd_go && req.code == tag_cmd_pkg::CMD_ARM && auth_ok && !frozen_q
    |=> armed_o)
    else $error("arm did not enable surveillance");

  frozen_hold_a: assert property (
    frozen_o |=> frozen_o && $stable(armed_o))
    else $error("frozen surveillance state changed");

  no_auth_a: assert property (
    cmd_go && is_alarm && !auth_ok
    |=> $stable(armed_o) && resp_o.err && resp_o.write_timing)
    else $error("alarm command ran without password");

  disarm_take_a: assert property (
    cmd_go && req.code == tag_cmd_pkg::CMD_DISARM && auth_ok && !frozen_q
    |=> !armed_o)
    else $error("disarm did not clear surveillance");

  freeze_take_a: assert property (
    cmd_go && req.code == tag_cmd_pkg::CMD_FREEZE && auth_ok |=> frozen_o)
    else $error("freeze did not lock surveillance");

  lock_err_a: assert property (
    cmd_go && auth_ok && frozen_q &&
    (req.code == tag_cmd_pkg::CMD_ARM || req.code == tag_cmd_pkg::CMD_DISARM)
    |=> resp_o.err && resp_o.err_code == tag_cmd_pkg::ERR_LOCKED)
    else $error("frozen arm or disarm not refused");

  alarm_timing_a: assert property (
    cmd_go && is_alarm |=> resp_o.write_timing && !resp_o.silent)
    else $error("alarm answer not write timed");

  alarm_ok_a: assert property (
    cmd_go && is_alarm && auth_ok && !frozen_q |=> !resp_o.err)
    else $error("permitted alarm command flagged an error");

  err_code_a: assert property (
    cmd_go && is_alarm |=> resp_o.err == (resp_o.err_code != 8'h00))
    else $error("error code present without error flag");

  census_rate_a: assert property (
    cmd_go && req.code == tag_cmd_pkg::CMD_CENSUS |=> !resp_o.fast_rate)
    else $error("plain census answered at double rate");

  sixteen_len_a: assert property (
    cmd_go && is_census && slots16 && req.flags[tag_cmd_pkg::FLG_OPTION] &&
    !(ext_mode && req.ext_opt[tag_cmd_pkg::EXT_FULL_ID]) && mask_bits < 7'd60
    |=> resp_o.id_bytes == 4'((8'd67 - {1'b0, $past(mask_bits)}) >> 3))
    else $error("sixteen slot truncated length wrong");

  trunc_zero_a: assert property (
    cmd_go && is_census && slots16 && req.flags[tag_cmd_pkg::FLG_OPTION] &&
    !(ext_mode && req.ext_opt[tag_cmd_pkg::EXT_FULL_ID]) && mask_bits >= 7'd60
    |=> resp_o.id_bytes == 4'h0)
    else $error("fully masked identifier not empty");

  full_data_a: assert property (
    cmd_go && is_census && ext_mode && req.flags[tag_cmd_pkg::FLG_OPTION] &&
    req.ext_opt[tag_cmd_pkg::EXT_FULL_ID] |=> resp_o.id_data == $past(uid_q))
    else $error("complete identifier not carried whole");

  no_id_data_a: assert property (
    cmd_go && is_census && !req.flags[tag_cmd_pkg::FLG_OPTION]
    |=> resp_o.id_data == 64'h0)
    else $error("identifier data present with option clear");

  addr_answer_a: assert property (
    cmd_go && is_census && !inv_mode && !req.flags[tag_cmd_pkg::FLG_SELECT] &&
    !(quiet_b && sticky_b) &&
    !(ext_mode && req.ext_opt[tag_cmd_pkg::EXT_ALARM_ONLY])
    |=> !resp_o.silent)
    else $error("addressed census not answered");

  select_only_a: assert property (
    cmd_go && is_census && !inv_mode && req.flags[tag_cmd_pkg::FLG_SELECT] &&
    !(quiet_b && sticky_b) && state_q != tag_cmd_pkg::ST_SELECTED
    |=> resp_o.silent)
    else $error("selected census answered outside selected state");

  inv_slot_a: assert property (
    cmd_go && is_census && inv_mode
    |=> !resp_o.first_slot && !resp_o.block_read)
    else $error("inventory census limited to first slot");

endmodule : tag_census_alarm
`default_nettype wire

//--- dv/reader_model.sv
// Reader-side model: turns interrogator requests into APB transfers.
// Assumes an APB slave on the same clock that may add wait states.
`timescale 1ns/1ps
`default_nettype none
module reader_model (
  input  wire logic        core_clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  // Same request pacing for every command, quick census too
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    do @(posedge core_clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released lines must not keep the old value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask : xfer

  // Inventory flag clear and no family byte ever sent
  task automatic plain_census(input logic sel, output logic [31:0] w);
    w = {8'h00, 8'h00, 8'h10, tag_cmd_pkg::CMD_CENSUS};
    if (!sel) begin
      w = {8'h00, 8'd64, 8'h00, tag_cmd_pkg::CMD_CENSUS};
    end
  endtask : plain_census
endmodule : reader_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the census and surveillance command block.
// Assumes the reader model drives APB and the design needs no long counts.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] CEN = tag_cmd_pkg::CMD_CENSUS;
  localparam logic [7:0] INV = 8'h04;
  localparam logic [7:0] OPT = 8'h40;
  localparam logic [63:0] NOAUTH = 64'(tag_cmd_pkg::ERR_NOAUTH);
  localparam logic [63:0] LOCKED = 64'(tag_cmd_pkg::ERR_LOCKED);
  logic                core_clk_i;
  logic                rst_i;
  logic                psel, penable, pwrite, pready, pslverr;
  logic                pulse, armed, frozen;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  tag_cmd_pkg::resp_t  resp;
  int                  errors = 0;
  int                  checked = 0;

  initial core_clk_i = 1'b0;
  always #5 core_clk_i = ~core_clk_i;

  reader_model reader_u (.core_clk_i(core_clk_i), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));
  tag_census_alarm dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .resp_o(resp),
    .resp_pulse_o(pulse), .armed_o(armed), .frozen_o(frozen));

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    reader_u.xfer(1'b1, a, d, q, e);
  endtask : wr

  // Waits a bounded time for the answer strobe, then samples settled
  task automatic cmd(input logic [31:0] w);
    logic hit;
    hit = 1'b0;
    wr(tag_cmd_pkg::OFF_CMD, w);
    // The strobe stands only for the cycle after the command edge
    for (int i = 0; i < 4 && !hit; i++) begin
      #1;
      hit = (pulse === 1'b1);
      if (!hit) begin
        @(posedge core_clk_i);
      end
    end
    chk("resp pulse", 64'h1, {63'h0, hit});
    @(posedge core_clk_i);
    #1;
    chk("pulse width", 64'h0, {63'h0, pulse});
  endtask : cmd

  task automatic state_is(input logic [1:0] s);
    logic [31:0] q;
    logic        e;
    reader_u.xfer(1'b0, tag_cmd_pkg::OFF_STATE, 32'h0, q, e);
    chk("state", {62'h0, s}, {62'h0, q[1:0]});
  endtask : state_is

  task automatic t_bus;
    logic [31:0] q;
    logic        e;
    chk("resp after reset", 64'h0, {41'h0, resp[22:0]});
    chk("ready", 64'h1, {63'h0, pready});
    state_is(2'd0);
    reader_u.xfer(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped err", 64'h1, {63'h0, e});
    chk("unmapped data", 64'h0, {32'h0, q});
  endtask : t_bus

  task automatic t_quiet;
    wr(tag_cmd_pkg::OFF_STATE, 32'h0);
    cmd({8'h00, 8'h80, INV, CEN});
    chk("silent keep", 64'h0, {63'h0, resp.silent});
    state_is(2'd0);
    cmd({8'h20, 8'h80, INV, CEN});
    chk("silent quiet", 64'h0, {63'h0, resp.silent});
    state_is(2'd2);
    wr(tag_cmd_pkg::OFF_STATE, 32'h0);
    cmd({8'h40, 8'h80, INV, CEN});
    chk("silent sticky", 64'h0, {63'h0, resp.silent});
    state_is(2'd3);
    cmd({8'h60, 8'h80, INV, CEN});
    chk("both in sticky", 64'h0, {63'h0, resp.silent});
    wr(tag_cmd_pkg::OFF_STATE, 32'h0);
    cmd({8'h60, 8'h80, INV, CEN});
    chk("both in ready", 64'h1, {63'h0, resp.silent});
  endtask : t_quiet

  task automatic t_ident;
    logic [6:0] mk [5] = '{7'd30, 7'd30, 7'd60, 7'd0, 7'd64};
    logic [7:0] fl [5] = '{INV, INV | 8'h20, INV, INV | 8'h20, INV | 8'h20};
    logic [3:0] nb [5] = '{4'd4, 4'd5, 4'd0, 4'd8, 4'd0};
    logic [63:0] uid = 64'h0123456789abcdef;
    logic [31:0] q;
    logic        e;
    wr(tag_cmd_pkg::OFF_UID_LO, 32'h89abcdef);
    wr(tag_cmd_pkg::OFF_UID_HI, 32'h01234567);
    wr(tag_cmd_pkg::OFF_STATE, 32'h0);
    for (int i = 0; i < 5; i++) begin
      cmd({8'h00, 1'b1, mk[i], fl[i] | OPT, CEN});
      chk("trunc bytes", {60'h0, nb[i]}, {60'h0, resp.id_bytes});
      chk("trunc id", uid >> (8 * (8 - nb[i])), resp.id_data);
    end
    cmd({8'h02, 8'h9e, INV | OPT, CEN});
    chk("full bytes", 64'h8, {60'h0, resp.id_bytes});
    chk("full id", 64'h0123456789abcdef, resp.id_data);
    reader_u.xfer(1'b0, tag_cmd_pkg::OFF_RID_LO, 32'h0, q, e);
    chk("rid lo", 64'h89abcdef, {32'h0, q});
    cmd({8'h02, 8'h9e, INV, CEN});
    chk("no id", 64'h0, {60'h0, resp.id_bytes});
  endtask : t_ident

  task automatic t_addr;
    logic [31:0] w;
    for (int s = 0; s < 2; s++) begin
      wr(tag_cmd_pkg::OFF_STATE, 32'h1);
      reader_u.plain_census(s[0], w);
      cmd(w);
      chk("accepted", 64'h0, {63'h0, resp.silent});
      chk("block read", 64'h1, {63'h0, resp.block_read});
      chk("first slot", 64'h1, {63'h0, resp.first_slot});
    end
    wr(tag_cmd_pkg::OFF_STATE, 32'h0);
    cmd(w);
    chk("select unselected", 64'h1, {63'h0, resp.silent});
  endtask : t_addr

  task automatic t_quick;
    wr(tag_cmd_pkg::OFF_STATE, 32'h0);
    cmd({8'h20, 8'h80, INV | 8'h01, tag_cmd_pkg::CMD_QUICK});
    chk("quick answers", 64'h0, {63'h0, resp.silent});
    chk("double rate", 64'h1, {63'h0, resp.fast_rate});
    chk("single sub", 64'h1, {63'h0, resp.single_sub});
    state_is(2'd2);
    wr(tag_cmd_pkg::OFF_STATE, 32'h0);
    cmd({8'h00, 8'h80, INV, CEN});
    chk("normal rate", 64'h0, {63'h0, resp.fast_rate});
  endtask : t_quick

  task automatic t_alarm;
    wr(tag_cmd_pkg::OFF_CTRL, 32'h1);
    cmd({24'h0, tag_cmd_pkg::CMD_ARM});
    chk("no password", NOAUTH, {56'h0, resp.err_code});
    chk("not armed", 64'h0, {63'h0, armed});
    wr(tag_cmd_pkg::OFF_CTRL, 32'h3);
    cmd({16'h0, OPT, tag_cmd_pkg::CMD_ARM});
    chk("armed", 64'h1, {63'h0, armed});
    chk("write timing", 64'h1, {63'h0, resp.write_timing});
    chk("arm ok", 64'h0, {63'h0, resp.err});
    cmd({24'h0, tag_cmd_pkg::CMD_DISARM});
    chk("disarmed", 64'h0, {63'h0, armed});
    cmd({24'h0, tag_cmd_pkg::CMD_ARM});
    cmd({24'h0, tag_cmd_pkg::CMD_FREEZE});
    chk("frozen", 64'h1, {63'h0, frozen});
    cmd({24'h0, tag_cmd_pkg::CMD_DISARM});
    chk("locked code", LOCKED, {56'h0, resp.err_code});
    chk("stays armed", 64'h1, {63'h0, armed});
  endtask : t_alarm

  task automatic close_out;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    rst_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_bus;
    t_quiet;
    t_ident;
    t_addr;
    t_quick;
    t_alarm;
    close_out;
  end

  // The whole run needs about 155 cycles; this cuts off a hang
  initial begin
    #200000;
    errors++;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
